//--- src/touch_cal_pkg.sv
/*
 touch calibration control: register indices, field layout, reset values,
 bus states and decode helpers.
 assumes a single clock domain; shared by the register bank and its timer.
*/
package touch_cal_pkg;
   localparam int ADDR_W = 8;
   localparam int BUS_W = 32;
   localparam int REG_W = 16;
   localparam int NUM_STAGES = 12;
   localparam int TMR_W = 10;
   localparam logic [5:0] IDX_CAL_EN = 6'h01;
   localparam logic [5:0] IDX_COMP_A = 6'h02;
   localparam logic [5:0] IDX_COMP_B = 6'h03;
   localparam logic [15:0] CAL_EN_RST = 16'h0000;
   localparam logic [15:0] COMP_A_RST = 16'h0ff0;
   localparam logic [15:0] COMP_B_RST = 16'h0164;
   localparam int FP_DROP_LSB = 12;
   localparam int LP_DROP_LSB = 14;
   localparam int FF_LSB = 0;
   localparam int FP_HOLD_LSB = 4;
   localparam int LP_HOLD_LSB = 8;
   localparam int TMO_LSB = 12;
   localparam int FORCE_BIT = 14;
   localparam int RESTART_BIT = 15;
   localparam int RECAL_LSB = 0;
   localparam int RATE_LSB = 8;
   localparam int SLOW_LSB = 14;
   localparam logic [3:0] FF_DROP_MAX = 4'hb;
   localparam int FP_HOLD_MUL = 16;
   localparam int LP_HOLD_MUL = 4;
   localparam int TMO_QUARTER = 4;
   localparam int TMO_BASE = 5;
   localparam logic [1:0] MODE_FULL = 2'h0;
   localparam logic [1:0] MODE_LOW = 2'h2;

   typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_DONE = 2'b10} bus_state_e;

   // 3, 7, 15, 31
   function automatic logic [4:0] fp_drop(input logic [1:0] c);
      return 5'((6'h04 << c) - 6'h01);
   endfunction : fp_drop

   function automatic logic [4:0] lp_drop(input logic [1:0] c);
      return {3'h0, c};
   endfunction : lp_drop

   function automatic logic [TMR_W-1:0] hold_limit(input logic [3:0] c, input logic full);
      return full ? TMR_W'(TMR_W'(c) * TMR_W'(FP_HOLD_MUL)) : TMR_W'(TMR_W'(c) * TMR_W'(LP_HOLD_MUL));
   endfunction : hold_limit

   // quarters of the full power hold period: (5..8)/4 x count x 16
   function automatic logic [TMR_W-1:0] tmo_limit(input logic [3:0] c, input logic [1:0] m);
      return TMR_W'(TMR_W'(c) * TMR_W'(TMO_QUARTER) * (TMR_W'(m) + TMR_W'(TMO_BASE)));
   endfunction : tmo_limit
endpackage : touch_cal_pkg

//--- src/cal_timer_if.sv
/*
 carrier between the register bank and a sequence-count timer.
 assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface cal_timer_if;
   import touch_cal_pkg::*;
   logic start;
   logic tick;
   logic [TMR_W-1:0] limit;
   logic active;
   logic expired;
   modport timer(input start, input tick, input limit, output active, output expired);
   modport user(output start, output tick, output limit, input active, input expired);
endinterface : cal_timer_if

//--- src/cal_timer.sv
/*
 sequence-count timer: start clears and arms on a nonzero limit, each tick counts one sequence,
 reaching the limit drops active and pulses expired for one cycle.
 assumes start and tick come from logic on clk_in.
*/
`timescale 1ns/1ps
module cal_timer (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // user side
   cal_timer_if.timer tif
);
   import touch_cal_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic active;
      logic expired;
   } tmr_s;

   tmr_s s_r;
   tmr_s s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.expired = 1'b0;
      if (tif.start) begin
         // a zero limit never arms: nothing to wait for
         s_nxt.cnt = '0;
         s_nxt.active = (tif.limit != '0);
      end else if (tif.tick && s_r.active) begin
         s_nxt.cnt = s_r.cnt + TMR_W'(1);
         if (s_r.cnt + TMR_W'(1) >= tif.limit) begin
            s_nxt.active = 1'b0;
            s_nxt.expired = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign tif.active = s_r.active;
   assign tif.expired = s_r.expired;

   property p_expire_only_on_tick;
      @(posedge clk_in) disable iff (!nrst_in)
         tif.expired |-> $past(tif.tick) && !$past(tif.start) && $past(s_r.active);
   endproperty
   a_expire_only_on_tick: assert property (p_expire_only_on_tick)
      else $error("timer expired without a counted sequence");
endmodule : cal_timer

//--- src/touch_calibration_control_regs.sv
/*
 calibration and compensation control registers of a touch controller,
 with per-stage calibration gating, averaging drop decode, fast filter
 admission, calibration hold and full-to-low power timeout.
 assumes an avalon-mm master on clk_in and a conversion core on the same
 clock that pulses seq_done_in once per finished sequence.
*/
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - one calibration enable per stage, bits 0..11, all reset to disabled
// - full power averaging drop code 00..11 gives 3, 7, 15, 31 samples
// - low power averaging drop code 00..11 gives 0, 1, 2, 3 samples
// - fast filter drops that many sequences per admitted one, code capped at 1011
// - full power calibration hold lasts count times 16 sequences
// - low power calibration hold lasts count times 4 sequences
// - full to low timeout is 1.25, 1.5, 1.75 or 2 times full hold
// - forced calibration bit makes every stage up to the programmed count recalibrate while set
// - writing bit 15 restarts the sequence at stage zero, then self-clears
// - mode 00 is full power, mode 10 low power; others run nothing
// - only stages below programmed count plus one are converted and calibrated
module touch_calibration_control_regs (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // avalon-mm slave
   input wire logic [touch_cal_pkg::ADDR_W-1:0] address_in,
   input wire logic read_in,
   input wire logic write_in,
   input wire logic [touch_cal_pkg::BUS_W-1:0] writedata_in,
   input wire logic [3:0] byteenable_in,
   output logic [touch_cal_pkg::BUS_W-1:0] readdata_out,
   output logic waitrequest_out,
   // conversion core status
   input wire logic [1:0] power_mode_in,
   input wire logic [3:0] stage_count_in,
   input wire logic seq_done_in,
   input wire logic touch_in,
   // conversion core control
   output logic [touch_cal_pkg::NUM_STAGES-1:0] stage_cal_go_out,
   output logic [4:0] average_drop_out,
   output logic fifo_admit_out,
   output logic seq_restart_out,
   output logic cal_suspend_out,
   output logic lp_request_out,
   output logic [7:0] near_touch_recal_level_out,
   output logic [5:0] detection_rate_out,
   output logic [1:0] slow_average_update_level_out
);
   import touch_cal_pkg::*;

   typedef struct packed {
      bus_state_e state;
      logic [REG_W-1:0] cal_en;
      logic [REG_W-1:0] comp_a;
      logic [REG_W-1:0] comp_b;
      logic [REG_W-1:0] rdata;
      logic [3:0] ff_cnt;
      logic [1:0] mode_prev;
      logic [NUM_STAGES-1:0] go;
      logic [4:0] drop;
      logic admit;
      logic restart;
      logic susp;
   } regs_s;

   regs_s s_r;
   regs_s s_nxt;

   function automatic logic reg_sel(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] == idx);
   endfunction : reg_sel

   logic full;
   logic low;
   logic running;
   logic wr;
   logic [REG_W-1:0] wmask;
   logic [REG_W-1:0] rd_val;
   logic [3:0] ff_code;
   logic [NUM_STAGES-1:0] stage_mask;

   cal_timer_if hold_if ();
   cal_timer_if tmo_if ();

   assign full = (power_mode_in == MODE_FULL);
   assign low = (power_mode_in == MODE_LOW);
   assign running = full | low;
   assign wr = (s_r.state == BUS_DONE) && write_in;
   assign wmask = {{8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
   // codes above the documented maximum behave as the maximum
   assign ff_code = (s_r.comp_a[FF_LSB+:4] > FF_DROP_MAX) ? FF_DROP_MAX : s_r.comp_a[FF_LSB+:4];

   // stage i takes part only if i <= programmed count
   genvar gi;
   generate
      for (gi = 0; gi < NUM_STAGES; gi++) begin : g_mask
         assign stage_mask[gi] = (4'(gi) <= stage_count_in);
      end
   endgenerate

   // hold restarts on every touched cycle, so it runs from release of touch
   assign hold_if.start = touch_in & running;
   assign hold_if.tick = seq_done_in & running;
   assign hold_if.limit = full ? hold_limit(s_r.comp_a[FP_HOLD_LSB+:4], 1'b1)
                               : hold_limit(s_r.comp_a[LP_HOLD_LSB+:4], 1'b0);

   // timeout rearms on touch and on entering full power, and is held cleared outside full power
   assign tmo_if.start = touch_in | ~full | (s_r.mode_prev != MODE_FULL);
   assign tmo_if.tick = seq_done_in & full;
   assign tmo_if.limit = tmo_limit(s_r.comp_a[FP_HOLD_LSB+:4], s_r.comp_a[TMO_LSB+:2]);

   cal_timer u_hold (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tif(hold_if.timer)
   );

   cal_timer u_tmo (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .tif(tmo_if.timer)
   );

   always_comb begin
      rd_val = '0;
      if (reg_sel(address_in, IDX_CAL_EN)) begin
         rd_val = s_r.cal_en;
      end else if (reg_sel(address_in, IDX_COMP_A)) begin
         rd_val = s_r.comp_a;
      end else if (reg_sel(address_in, IDX_COMP_B)) begin
         rd_val = s_r.comp_b;
      end
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.admit = 1'b0;
      s_nxt.restart = 1'b0;
      s_nxt.mode_prev = power_mode_in;
      // one wait cycle: data is captured in idle and stands while done
      case (s_r.state)
         BUS_IDLE: begin
            if (read_in || write_in) begin
               s_nxt.state = BUS_DONE;
               s_nxt.rdata = rd_val;
            end
         end
         BUS_DONE: begin
            s_nxt.state = BUS_IDLE;
         end
         default: begin
            s_nxt.state = BUS_IDLE;
         end
      endcase
      if (wr && reg_sel(address_in, IDX_CAL_EN)) begin
         s_nxt.cal_en = (s_r.cal_en & ~wmask) | (writedata_in[REG_W-1:0] & wmask);
      end
      if (wr && reg_sel(address_in, IDX_COMP_A)) begin
         s_nxt.comp_a = (s_r.comp_a & ~wmask) | (writedata_in[REG_W-1:0] & wmask);
         // acted on at once, so the stored bit never reads back as one
         s_nxt.comp_a[RESTART_BIT] = 1'b0;
         s_nxt.restart = writedata_in[RESTART_BIT] & byteenable_in[1];
      end
      if (wr && reg_sel(address_in, IDX_COMP_B)) begin
         s_nxt.comp_b = (s_r.comp_b & ~wmask) | (writedata_in[REG_W-1:0] & wmask);
      end
      if (s_r.restart) begin
         s_nxt.ff_cnt = '0;
      end else if (seq_done_in && running) begin
         if (s_r.ff_cnt >= ff_code) begin
            s_nxt.admit = 1'b1;
            s_nxt.ff_cnt = '0;
         end else begin
            s_nxt.ff_cnt = s_r.ff_cnt + 4'h1;
         end
      end
      s_nxt.susp = running & (touch_in | hold_if.active);
      // forced calibration overrides both the enables and the hold
      if (running) begin
         s_nxt.go = ((s_r.cal_en[NUM_STAGES-1:0] & ~{NUM_STAGES{s_r.susp}})
                     | {NUM_STAGES{s_r.comp_a[FORCE_BIT]}}) & stage_mask;
      end else begin
         s_nxt.go = '0;
      end
      if (full) begin
         s_nxt.drop = fp_drop(s_r.cal_en[FP_DROP_LSB+:2]);
      end else if (low) begin
         s_nxt.drop = lp_drop(s_r.cal_en[LP_DROP_LSB+:2]);
      end else begin
         s_nxt.drop = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         s_r.state <= BUS_IDLE;
         s_r.cal_en <= CAL_EN_RST;
         s_r.comp_a <= COMP_A_RST;
         s_r.comp_b <= COMP_B_RST;
         s_r.rdata <= '0;
         s_r.ff_cnt <= '0;
         s_r.mode_prev <= MODE_FULL;
         s_r.go <= '0;
         s_r.drop <= '0;
         s_r.admit <= 1'b0;
         s_r.restart <= 1'b0;
         s_r.susp <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign waitrequest_out = (read_in || write_in) && (s_r.state != BUS_DONE);
   assign readdata_out = {{(BUS_W-REG_W){1'b0}}, s_r.rdata};
   assign stage_cal_go_out = s_r.go;
   assign average_drop_out = s_r.drop;
   assign fifo_admit_out = s_r.admit;
   assign seq_restart_out = s_r.restart;
   assign cal_suspend_out = s_r.susp;
   assign lp_request_out = tmo_if.expired;
   assign near_touch_recal_level_out = s_r.comp_b[RECAL_LSB+:8];
   assign detection_rate_out = s_r.comp_b[RATE_LSB+:6];
   assign slow_average_update_level_out = s_r.comp_b[SLOW_LSB+:2];

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   property p_cal_gate;
      ##1 (stage_cal_go_out & ~$past(s_r.cal_en[NUM_STAGES-1:0])
           & ~{NUM_STAGES{$past(s_r.comp_a[FORCE_BIT])}}) == '0;
   endproperty
   a_cal_gate: assert property (p_cal_gate)
      else $error("stage calibrated while its enable was clear");

   property p_fp_drop;
      // the release edge still sees registers held in reset, so attempts start after it
      nrst_in && full |=> average_drop_out == fp_drop($past(s_r.cal_en[FP_DROP_LSB+:2]));
   endproperty
   a_fp_drop: assert property (p_fp_drop)
      else $error("full power averaging drop decoded wrongly");

   property p_lp_drop;
      nrst_in && low |=> average_drop_out == lp_drop($past(s_r.cal_en[LP_DROP_LSB+:2]));
   endproperty
   a_lp_drop: assert property (p_lp_drop)
      else $error("low power averaging drop decoded wrongly");

   property p_admit;
      fifo_admit_out |-> $past(seq_done_in) && $past(running) && !$past(s_r.restart);
   endproperty
   a_admit: assert property (p_admit)
      else $error("fifo admission without a finished sequence");

   property p_admit_zero;
      seq_done_in && running && !s_r.restart && ff_code == 4'h0 |=> fifo_admit_out;
   endproperty
   a_admit_zero: assert property (p_admit_zero)
      else $error("zero drop code failed to admit a sequence");

   property p_touch_holds;
      nrst_in && touch_in && running |=> cal_suspend_out
         ##1 (stage_cal_go_out & ~{NUM_STAGES{$past(s_r.comp_a[FORCE_BIT])}}) == '0;
   endproperty
   a_touch_holds: assert property (p_touch_holds)
      else $error("touch did not suspend calibration");

   property p_lp_req;
      lp_request_out |-> $past(full) && !$past(touch_in);
   endproperty
   a_lp_req: assert property (p_lp_req)
      else $error("low power request outside full power idle");

   property p_forced;
      nrst_in && running && s_r.comp_a[FORCE_BIT] |=> stage_cal_go_out == $past(stage_mask);
   endproperty
   a_forced: assert property (p_forced)
      else $error("forced calibration missed a stage");

   property p_restart;
      wr && reg_sel(address_in, IDX_COMP_A) && writedata_in[RESTART_BIT] && byteenable_in[1]
         |=> seq_restart_out && !s_r.comp_a[RESTART_BIT] ##1 !seq_restart_out;
   endproperty
   a_restart: assert property (p_restart)
      else $error("sequence restart not a single self-clearing pulse");

   property p_idle_mode;
      !running |=> stage_cal_go_out == '0 && average_drop_out == '0;
   endproperty
   a_idle_mode: assert property (p_idle_mode)
      else $error("conversion control active in shutdown mode");

   property p_stage_range;
      ##1 (stage_cal_go_out & ~$past(stage_mask)) == '0;
   endproperty
   a_stage_range: assert property (p_stage_range)
      else $error("stage beyond sequence length calibrated");

   property p_readback;
      wr && reg_sel(address_in, IDX_CAL_EN) && byteenable_in[1:0] == 2'h3
         |=> s_r.cal_en == $past(writedata_in[REG_W-1:0]);
   endproperty
   a_readback: assert property (p_readback)
      else $error("written enable value not stored");

   property p_one_wait;
      nrst_in && (read_in || write_in) && s_r.state == BUS_IDLE |=> !waitrequest_out;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("bus request not answered after one wait cycle");

   property p_read_comp;
      nrst_in && s_r.state == BUS_IDLE && read_in && reg_sel(address_in, IDX_COMP_A)
         |=> readdata_out == {{(BUS_W-REG_W){1'b0}}, $past(s_r.comp_a)};
   endproperty
   a_read_comp: assert property (p_read_comp)
      else $error("compensation register read back wrongly");

   property p_restart_low;
      !s_r.comp_a[RESTART_BIT];
   endproperty
   a_restart_low: assert property (p_restart_low)
      else $error("self-clearing restart bit stored as one");

   property p_shutdown_quiet;
      !running |=> !cal_suspend_out && !fifo_admit_out && !lp_request_out;
   endproperty
   a_shutdown_quiet: assert property (p_shutdown_quiet)
      else $error("hold, admission or timeout active in shutdown mode");

   property p_lp_pulse;
      lp_request_out |=> !lp_request_out;
   endproperty
   a_lp_pulse: assert property (p_lp_pulse)
      else $error("low power request longer than one cycle");

   property p_hold_release;
      nrst_in && running && !touch_in && !hold_if.active |=> !cal_suspend_out;
   endproperty
   a_hold_release: assert property (p_hold_release)
      else $error("calibration still held after hold period ended");

   property p_enable_pass;
      nrst_in && running && !s_r.susp && !s_r.comp_a[FORCE_BIT]
         |=> stage_cal_go_out == ($past(s_r.cal_en[NUM_STAGES-1:0]) & $past(stage_mask));
   endproperty
   a_enable_pass: assert property (p_enable_pass)
      else $error("enabled stage not granted calibration");
endmodule : touch_calibration_control_regs

//--- verif/core_model.sv
/*
 conversion core stand-in: pulses seq_done_out once every GAP cycles while
 run_in is high, and stays quiet otherwise.
 assumes clk_in and nrst_in of the register bank.
*/
`timescale 1ns/1ps
module core_model #(
   parameter int GAP = 4
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic nrst_in,
   // control from the bench
   input wire logic run_in,
   // core status
   output logic seq_done_out
);
   logic [7:0] cnt_r;

   // gap of several cycles keeps each pulse apart from its registered effects
   always_ff @(posedge clk_in) begin
      if (!nrst_in || !run_in) begin
         cnt_r <= 8'h00;
         seq_done_out <= 1'b0;
      end else begin
         cnt_r <= (cnt_r == 8'(GAP - 1)) ? 8'h00 : cnt_r + 8'h01;
         seq_done_out <= (cnt_r == 8'(GAP - 1)); // one pulse per sequence
      end
   end
endmodule : core_model

//--- verif/testbench.sv
/*
 testbench for the calibration control registers: register table, decode,
 fast filter admission, calibration hold, timeout and reset.
 assumes core_model as the source of sequence pulses.
*/
`timescale 1ns/1ps
module testbench;
   import touch_cal_pkg::*;
   typedef struct {logic [7:0] a; logic [15:0] d; logic [3:0] be; logic [15:0] x;} row_s;
   logic clk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'h0;
   logic [1:0] mode = 2'h0;
   logic [3:0] scount = 4'hb;
   logic touch = 1'b0;
   logic run = 1'b0;
   logic seq_done, wreq, admit, rstp, susp, lpreq;
   logic [31:0] rdata, rd;
   logic [11:0] go;
   logic [4:0] drop;
   logic [7:0] lvl;
   logic [5:0] rate;
   logic [1:0] slow;
   logic [4:0] fp_tab [4] = '{5'h03, 5'h07, 5'h0f, 5'h1f};
   logic [3:0] ff_code [5] = '{4'h0, 4'h1, 4'h2, 4'hb, 4'hf};
   row_s rows [7];
   int err_count = 0;
   int n_compared = 0;
   int restarts = 0;
   int n;

   always #2 clk_in = ~clk_in;
   always @(negedge clk_in) if (rstp === 1'b1) restarts++;

   touch_calibration_control_regs dut_u (
      .clk_in(clk_in), .nrst_in(nrst_in), .address_in(addr), .read_in(rd_en),
      .write_in(wr_en), .writedata_in(wdata), .byteenable_in(be),
      .readdata_out(rdata), .waitrequest_out(wreq), .power_mode_in(mode),
      .stage_count_in(scount), .seq_done_in(seq_done), .touch_in(touch),
      .stage_cal_go_out(go), .average_drop_out(drop), .fifo_admit_out(admit),
      .seq_restart_out(rstp), .cal_suspend_out(susp), .lp_request_out(lpreq),
      .near_touch_recal_level_out(lvl), .detection_rate_out(rate),
      .slow_average_update_level_out(slow)
   );

   core_model #(.GAP(4)) core_u (
      .clk_in(clk_in), .nrst_in(nrst_in), .run_in(run), .seq_done_out(seq_done)
   );

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // request held until the edge that sees waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input logic [3:0] b, output logic [31:0] q);
      int i;
      @(posedge clk_in);
      addr <= a;
      wdata <= {16'h0000, d};
      be <= b;
      wr_en <= wr;
      rd_en <= !wr;
      // waitrequest sampled at the rising edge, before that edge's updates land
      for (i = 0; i < 50; i++) begin
         @(posedge clk_in);
         if (wreq === 1'b0) break;
      end
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      if (i == 50) begin
         err_count++;
         give_verdict();
      end
   endtask : bus

   task automatic wt(input int c);
      repeat (c) @(negedge clk_in);
   endtask : wt

   // touch with the core idle, then count sequences until hold ends or timeout
   task automatic count_seq(input logic lp, output int k);
      int i;
      k = 0;
      @(posedge clk_in);
      touch <= 1'b1;
      run <= 1'b0;
      repeat (3) @(posedge clk_in);
      touch <= 1'b0;
      run <= 1'b1;
      for (i = 0; i < 2000; i++) begin
         @(negedge clk_in);
         if (lp ? lpreq === 1'b1 : susp !== 1'b1) break;
         if (seq_done === 1'b1) k++;
      end
      @(posedge clk_in);
      run <= 1'b0;
      if (i == 2000) begin
         err_count++;
         give_verdict();
      end
   endtask : count_seq

   task automatic count_admit(input int pulses, output int k);
      int i;
      int p;
      i = 0;
      p = 0;
      k = 0;
      @(posedge clk_in);
      run <= 1'b1;
      while (p < pulses && i < 2000) begin
         @(negedge clk_in);
         i++;
         if (seq_done === 1'b1) p++;
         if (admit === 1'b1) k++;
      end
      @(posedge clk_in);
      run <= 1'b0;
      repeat (3) begin
         @(negedge clk_in);
         if (admit === 1'b1) k++;
      end
      if (i == 2000) begin
         err_count++;
         give_verdict();
      end
   endtask : count_admit

   initial begin
      rows[0] = '{8'h04, 16'hffff, 4'h3, 16'hffff};
      rows[1] = '{8'h04, 16'h00aa, 4'h1, 16'hffaa};
      rows[2] = '{8'h04, 16'h5500, 4'h2, 16'h55aa};
      rows[3] = '{8'h08, 16'h8abc, 4'h3, 16'h0abc};
      rows[4] = '{8'h0c, 16'hc7ab, 4'h3, 16'hc7ab};
      rows[5] = '{8'h10, 16'h1234, 4'h3, 16'h0000};
      rows[6] = '{8'h00, 16'h1234, 4'h3, 16'h0000};
      repeat (16) @(posedge clk_in);
      nrst_in <= 1'b1;
      foreach (rows[k]) begin
         bus(1'b1, rows[k].a, rows[k].d, rows[k].be, rd);
         bus(1'b0, rows[k].a, 16'h0000, 4'hf, rd);
         chk(rd, {16'h0000, rows[k].x});
      end
      wt(3);
      chk({lvl, rate, slow}, {8'hab, 6'h07, 2'h3});
      chk(restarts, 1);
      $display("test registers done");
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 4; c++) begin
            @(posedge clk_in);
            mode <= 2'(m);
            bus(1'b1, 8'h04, {2'(c), 2'(c), 12'h000}, 4'h3, rd);
            wt(3);
            chk(drop, m == 0 ? fp_tab[c] : (m == 2 ? 5'(c) : 5'h00));
         end
      end
      $display("test averaging done");
      @(posedge clk_in);
      mode <= 2'h0;
      bus(1'b1, 8'h04, 16'h0a5a, 4'h3, rd);
      wt(3);
      chk(go, 12'ha5a);
      @(posedge clk_in);
      scount <= 4'h3;
      wt(3);
      chk(go, 12'h00a);
      @(posedge clk_in);
      touch <= 1'b1;
      wt(4);
      chk({susp, go}, {1'b1, 12'h000});
      bus(1'b1, 8'h08, 16'h4ff0, 4'h3, rd);
      wt(3);
      chk(go, 12'h00f);
      bus(1'b1, 8'h08, 16'h0ff0, 4'h3, rd);
      touch <= 1'b0;
      scount <= 4'hb;
      $display("test stage gating done");
      foreach (ff_code[j]) begin
         bus(1'b1, 8'h08, {8'h8f, 4'hf, ff_code[j]}, 4'h3, rd);
         count_admit(24, n);
         chk(n, 24 / (ff_code[j] > 4'hb ? 12 : ff_code[j] + 1));
      end
      chk(restarts, 6);
      $display("test admission done");
      bus(1'b1, 8'h08, 16'h0320, 4'h3, rd);
      count_seq(1'b0, n);
      chk(n, 32);
      mode <= 2'h2;
      count_seq(1'b0, n);
      chk(n, 12);
      $display("test hold done");
      mode <= 2'h0;
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 8'h08, {2'h0, 2'(c), 12'h110}, 4'h3, rd);
         count_seq(1'b1, n);
         chk(n, 4 * (5 + c));
      end
      $display("test timeout done");
      // second reset in mid-run must restore the table values
      @(posedge clk_in);
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      bus(1'b0, 8'h04, 16'h0000, 4'hf, rd);
      chk(rd, 32'h0000);
      bus(1'b0, 8'h08, 16'h0000, 4'hf, rd);
      chk(rd, 32'h0ff0);
      bus(1'b0, 8'h0c, 16'h0000, 4'hf, rd);
      chk(rd, 32'h0164);
      wt(3);
      chk({drop, go}, {5'h03, 12'h000});
      $display("test reset done");
      give_verdict();
   end
endmodule : testbench
